// file: src/irf_defs.svh
// Purpose: Offsets, field positions, reset values and timing figures of the
//          isochronous event, fairness and link control register block.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Definitions only; no logic lives here.
`ifndef IRF_DEFS_SVH
`define IRF_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets (low address byte only).
// ----------------------------------------------------------------------------
`define IRF_TX_ENABLE_SET 8'h98
`define IRF_TX_ENABLE_CLEAR 8'h9c
`define IRF_RX_FLAGS_SET 8'ha0
`define IRF_RX_FLAGS_CLEAR 8'ha4
`define IRF_RX_ENABLE_SET 8'ha8
`define IRF_RX_ENABLE_CLEAR 8'hac
`define IRF_ARB_FAIRNESS 8'hdc
`define IRF_LINK_FLAGS_SET 8'he0
`define IRF_LINK_FLAGS_CLEAR 8'he4

// ----------------------------------------------------------------------------
// Field widths and positions.
// ----------------------------------------------------------------------------
`define IRF_TX_CTX 8
`define IRF_RX_CTX 4
`define IRF_FAIR_W 8
`define IRF_LINK_EXT_BIT 22
`define IRF_LINK_MASTER_BIT 21
`define IRF_LINK_COUNT_BIT 20
`define IRF_LINK_PHY_BIT 10
`define IRF_LINK_SELFID_BIT 9
`define IRF_LINK_IMPL_MASK 32'h0070_0600

// ----------------------------------------------------------------------------
// Reset values and bus encodings.
// ----------------------------------------------------------------------------
`define IRF_FAIR_RESET 8'h00
`define IRF_HTRANS_NONSEQ 2'b10
`define IRF_HSIZE_WORD 3'b010

// ----------------------------------------------------------------------------
// Timing: system clock, cycle timer base clock and cycle length.
// ----------------------------------------------------------------------------
`define IRF_CLK_KHZ 100000
`define IRF_TICK_KHZ 24576
`define IRF_CYCLE_TICKS 3072

`endif

// file: src/irf_pkg.sv
// Purpose: Types shared by the isochronous event and link control block.
// Assumes: Widths follow the register layout and never change.
// Notes:   Every module keeps all its state in one of these structs.
package irf_pkg;

  // --------------------------------------------------------------------------
  // Register access carried from the bus slave to the register file.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } irf_reg_req_t;

  // Implemented link control flags.
  typedef struct packed {
    logic ext_sel;
    logic master;
    logic cnt_en;
    logic phy;
    logic selfid;
  } irf_link_t;

  // --------------------------------------------------------------------------
  // Per-module state.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic pend;
    logic write;
    logic [7:0] addr;
    logic [31:0] rdata;
  } irf_ahb_state_t;

  typedef struct packed {
    logic [16:0] acc;
    logic [11:0] offset;
    logic roll;
    logic [2:0] pin_sync;
  } irf_ct_state_t;

  typedef struct packed {
    logic [7:0] tx_mask;
    logic [3:0] rx_flags;
    logic [3:0] rx_mask;
    logic [3:0] rx_irq_prev;
    irf_link_t link;
    logic ocl_prev;
    logic [7:0] fair;
  } irf_main_state_t;

endpackage : irf_pkg

// file: src/irf_ahb_slave.sv
// Purpose: AHB-Lite slave that turns single word transfers into register
//          accesses.
// Assumes: One slave on the bus, so hreadyout is also the bus hready.
// Notes:   Every whole-word NONSEQ transfer takes one wait state; read data leave a flop.
`timescale 1ns/100ps
`include "irf_defs.svh"

module irf_ahb_slave
  import irf_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Register file side.
  output irf_reg_req_t req,
  input wire logic [31:0] rd_data
);

  irf_ahb_state_t st_q;
  irf_ahb_state_t st_d;
  logic take;

  // Only whole-word NONSEQ transfers are acted on; others still end OKAY.
  assign take = hsel && hready && (htrans == `IRF_HTRANS_NONSEQ) &&
                (hsize == `IRF_HSIZE_WORD);

  // --------------------------------------------------------------------------
  // Next state: capture the address phase, then do the access one cycle on.
  // --------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.pend = take;
    if (take) begin
      st_d.write = hwrite;
      st_d.addr = haddr[7:0];
    end
    // Read data are caught while the wait state stands.
    if (st_q.pend && !st_q.write) begin
      st_d.rdata = rd_data;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // The wait state holds the master while the register file acts.
  assign hreadyout = !st_q.pend;
  assign hrdata = st_q.rdata;
  assign hresp = 1'b0;
  assign req.wr = st_q.pend && st_q.write;
  assign req.rd = st_q.pend && !st_q.write;
  assign req.addr = st_q.addr;
  assign req.wdata = hwdata;

endmodule : irf_ahb_slave

// file: src/irf_cycle_timer.sv
// Purpose: Cycle timer offset counter with internal or external rollover.
// Assumes: 100 MHz clk; the base rate is made by a fractional accumulator.
// Notes:   The external cycle pin is synchronised before any use.
`timescale 1ns/100ps
`include "irf_defs.svh"

module irf_cycle_timer
  import irf_pkg::*;
#(
  parameter int unsigned CYCLE_TICKS = `IRF_CYCLE_TICKS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control from the link flags.
  input wire logic enable,
  input wire logic ext_select,
  // External cycle pin, asynchronous.
  input wire logic cycle_in,
  // Timer state.
  output logic roll_o,
  output logic [11:0] offset_o
);

  localparam logic [16:0] STEP = 17'(`IRF_TICK_KHZ);
  localparam logic [16:0] LIMIT = 17'(`IRF_CLK_KHZ);
  localparam logic [11:0] LAST_OFF = 12'(CYCLE_TICKS - 1);

  // The offset counter is twelve bits wide.
  if (CYCLE_TICKS < 2 || CYCLE_TICKS > 4096) begin : g_bad_ticks
    $error("CYCLE_TICKS must lie between 2 and 4096");
  end

  irf_ct_state_t st_q;
  irf_ct_state_t st_d;
  logic [16:0] acc_sum;
  logic tick;
  logic pin_rise;

  // Base clock ticks average 24.576 per microsecond; jitter is one clk.
  assign acc_sum = st_q.acc + STEP;
  assign tick = acc_sum >= LIMIT;
  // Edge seen between second and third stage only.
  assign pin_rise = st_q.pin_sync[1] && !st_q.pin_sync[2];

  // --------------------------------------------------------------------------
  // Next state.
  // --------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.pin_sync = {st_q.pin_sync[1:0], cycle_in};
    st_d.roll = 1'b0;
    if (enable) begin
      st_d.acc = tick ? acc_sum - LIMIT : acc_sum;
      if (ext_select) begin
        // External rollover restarts the offset at the pin edge.
        if (pin_rise) begin
          st_d.offset = '0;
          st_d.roll = 1'b1;
        end else if (tick && st_q.offset != 12'hfff) begin
          st_d.offset = st_q.offset + 12'h001;
        end
      end else if (tick) begin
        // An offset left past the end by external mode wraps at the next tick.
        if (st_q.offset >= LAST_OFF) begin
          st_d.offset = '0;
          st_d.roll = 1'b1;
        end else begin
          st_d.offset = st_q.offset + 12'h001;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign roll_o = st_q.roll;
  assign offset_o = st_q.offset;

  // Internal rollover happens only at or past the last offset.
  chk_internal_wrap:
  assert property (@(posedge clk) disable iff (rst)
    (roll_o && !$past(ext_select)) |-> ($past(offset_o) >= LAST_OFF))
  else $error("internal rollover from a wrong offset");

  // A stopped timer neither counts nor rolls.
  chk_timer_hold:
  assert property (@(posedge clk) disable iff (rst)
    !$past(enable) |-> (offset_o == $past(offset_o)) && !roll_o)
  else $error("cycle timer moved while disabled");

endmodule : irf_cycle_timer

// file: src/irf_regs.sv
// Purpose: Isochronous context event and enable registers, fairness limit
//          and link control flags behind an AHB-Lite slave.
// Assumes: Context interrupt lines, event inputs and the fairness limit come
//          from logic on clk; only the external cycle pin is asynchronous.
// Notes:   Unimplemented bits read as zero; every flop resets to zero.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`include "irf_defs.svh"

// Behaviour
// - Transmit enables set and cleared by ones
// - Both transmit enable addresses read the mask
// - Eight transmit enables, upper bits read zero
// - Receive flags have set and clear addresses
// - Clear address reads flags AND enables
// - Completed input command with interrupt raises flag
// - Flag set by rising edge or set write
// - Only a clear-address one clears a flag
// - Four receive flags, upper bits read zero
// - Receive enables set and cleared by ones
// - Both receive enable addresses read the mask
// - Receive enables gate summary; upper bits zero
// - Read-only fairness limit, resets to zero
// - Link flags have set and clear addresses
// - Five link bits; master also hardware-changed
// - Overlong cycle drops master, blocks setting
// - Internal rollover at 3072 ticks, else external
module irf_regs
  import irf_pkg::*;
#(
  parameter int unsigned CYCLE_TICKS = `IRF_CYCLE_TICKS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite register bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Transmit side: event flags kept by the neighbouring event register.
  input wire logic [7:0] tx_event_flags,
  output logic tx_summary_irq,
  // Receive side: one completion interrupt line per context.
  input wire logic [3:0] rx_ctx_irq,
  output logic rx_summary_irq,
  // Cycle timer events and pins.
  input wire logic overlong_cycle_event,
  input wire logic cycle_in,
  output logic cycle_rollover,
  output logic [11:0] cycle_offset,
  // Fairness limit from the arbitration logic.
  input wire logic [7:0] fairness_limit,
  output logic [7:0] pri_req_limit,
  // Link control flags to the link core.
  output logic external_cycle_select,
  output logic cycle_start_generator_enable,
  output logic cycle_count_enable,
  output logic accept_phy_packets,
  output logic accept_self_id_packets
);

  // --------------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------------
  irf_reg_req_t req; // Access decoded by the bus slave.
  logic [31:0] rd_data; // Read value for the current access.
  logic [31:0] wdata; // Write data of the current access.
  irf_main_state_t st_q; // All register state.
  irf_main_state_t st_d; // Its next value.
  logic [3:0] rx_edge; // Rising edges of the context interrupt lines.
  logic [3:0] rx_set_vec; // Flags set by software this cycle.
  logic [3:0] rx_clr_vec; // Flags cleared by software this cycle.
  logic ocl_rise; // Start of an overlong cycle event.
  logic [31:0] link_word; // Link flags placed at their bit positions.

  // --------------------------------------------------------------------------
  // Bus slave and cycle timer.
  // --------------------------------------------------------------------------
  irf_ahb_slave u_slave (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .req(req),
    .rd_data(rd_data)
  );

  // The timer follows the count enable and source flags.
  irf_cycle_timer #(
    .CYCLE_TICKS(CYCLE_TICKS)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .enable(st_q.link.cnt_en),
    .ext_select(st_q.link.ext_sel),
    .cycle_in(cycle_in),
    .roll_o(cycle_rollover),
    .offset_o(cycle_offset)
  );

  // --------------------------------------------------------------------------
  // Event detection and software strobes.
  // --------------------------------------------------------------------------
  assign wdata = req.wdata;

  // A context interrupt line pulses when an input command finishes with
  // its interrupt bits set; only the edge counts, so a held line sets once.
  assign rx_edge = rx_ctx_irq & ~st_q.rx_irq_prev;

  // Set and clear strobes of the receive flags.
  assign rx_set_vec = (req.wr && req.addr == `IRF_RX_FLAGS_SET) ?
                      wdata[3:0] : 4'h0;
  assign rx_clr_vec = (req.wr && req.addr == `IRF_RX_FLAGS_CLEAR) ?
                      wdata[3:0] : 4'h0;

  // The master flag is dropped once per overlong cycle event.
  assign ocl_rise = overlong_cycle_event && !st_q.ocl_prev;

  // Link flags at their positions; all other bits read zero.
  always_comb begin
    link_word = 32'h0000_0000;
    link_word[`IRF_LINK_EXT_BIT] = st_q.link.ext_sel;
    link_word[`IRF_LINK_MASTER_BIT] = st_q.link.master;
    link_word[`IRF_LINK_COUNT_BIT] = st_q.link.cnt_en;
    link_word[`IRF_LINK_PHY_BIT] = st_q.link.phy;
    link_word[`IRF_LINK_SELFID_BIT] = st_q.link.selfid;
  end

  // --------------------------------------------------------------------------
  // Next state of every register.
  // --------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // Transmit enables: ones set at one address and clear at the other.
    if (req.wr && req.addr == `IRF_TX_ENABLE_SET) begin
      st_d.tx_mask = st_q.tx_mask | wdata[7:0];
    end else if (req.wr && req.addr == `IRF_TX_ENABLE_CLEAR) begin
      st_d.tx_mask = st_q.tx_mask & ~wdata[7:0];
    end

    // Receive flags: a hardware edge in the cycle of a clear wins, so no
    // completion is ever lost to software acknowledging an older one.
    st_d.rx_irq_prev = rx_ctx_irq;
    st_d.rx_flags = (st_q.rx_flags & ~rx_clr_vec) | rx_set_vec | rx_edge;

    // Receive enables.
    if (req.wr && req.addr == `IRF_RX_ENABLE_SET) begin
      st_d.rx_mask = st_q.rx_mask | wdata[3:0];
    end else if (req.wr && req.addr == `IRF_RX_ENABLE_CLEAR) begin
      st_d.rx_mask = st_q.rx_mask & ~wdata[3:0];
    end

    // Link flags: ones set or clear the implemented positions.
    if (req.wr && req.addr == `IRF_LINK_FLAGS_SET) begin
      if (wdata[`IRF_LINK_EXT_BIT]) begin
        st_d.link.ext_sel = 1'b1;
      end
      // Setting the master flag is refused while the overlong event stands.
      if (wdata[`IRF_LINK_MASTER_BIT] && !overlong_cycle_event) begin
        st_d.link.master = 1'b1;
      end
      if (wdata[`IRF_LINK_COUNT_BIT]) begin
        st_d.link.cnt_en = 1'b1;
      end
      if (wdata[`IRF_LINK_PHY_BIT]) begin
        st_d.link.phy = 1'b1;
      end
      if (wdata[`IRF_LINK_SELFID_BIT]) begin
        st_d.link.selfid = 1'b1;
      end
    end else if (req.wr && req.addr == `IRF_LINK_FLAGS_CLEAR) begin
      if (wdata[`IRF_LINK_EXT_BIT]) begin
        st_d.link.ext_sel = 1'b0;
      end
      if (wdata[`IRF_LINK_MASTER_BIT]) begin
        st_d.link.master = 1'b0;
      end
      if (wdata[`IRF_LINK_COUNT_BIT]) begin
        st_d.link.cnt_en = 1'b0;
      end
      if (wdata[`IRF_LINK_PHY_BIT]) begin
        st_d.link.phy = 1'b0;
      end
      if (wdata[`IRF_LINK_SELFID_BIT]) begin
        st_d.link.selfid = 1'b0;
      end
    end

    // Hardware drops the master flag last, so it beats any write.
    if (ocl_rise) begin
      st_d.link.master = 1'b0;
    end
    st_d.ocl_prev = overlong_cycle_event;

    // Fairness limit is loaded from the arbiter; writes cannot reach it.
    st_d.fair = fairness_limit;
  end

  // State register; reset brings every flag and the fairness field to zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read data. Unmapped offsets read zero and are still answered OKAY.
  // --------------------------------------------------------------------------
  always_comb begin
    case (req.addr)
      `IRF_TX_ENABLE_SET, `IRF_TX_ENABLE_CLEAR: begin
        rd_data = {24'h00_0000, st_q.tx_mask};
      end
      `IRF_RX_FLAGS_SET: begin
        rd_data = {28'h000_0000, st_q.rx_flags};
      end
      `IRF_RX_FLAGS_CLEAR: begin
        rd_data = {28'h000_0000, st_q.rx_flags & st_q.rx_mask};
      end
      `IRF_RX_ENABLE_SET, `IRF_RX_ENABLE_CLEAR: begin
        rd_data = {28'h000_0000, st_q.rx_mask};
      end
      `IRF_ARB_FAIRNESS: begin
        rd_data = {24'h00_0000, st_q.fair};
      end
      `IRF_LINK_FLAGS_SET, `IRF_LINK_FLAGS_CLEAR: begin
        rd_data = link_word;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Outputs. Both summaries are built from flops; the transmit flags come
  // from the neighbouring event register on the same clock.
  // --------------------------------------------------------------------------
  assign tx_summary_irq = |(tx_event_flags & st_q.tx_mask);
  assign rx_summary_irq = |(st_q.rx_flags & st_q.rx_mask);
  assign pri_req_limit = st_q.fair;
  assign external_cycle_select = st_q.link.ext_sel;
  assign cycle_start_generator_enable = st_q.link.master;
  assign cycle_count_enable = st_q.link.cnt_en;
  assign accept_phy_packets = st_q.link.phy;
  assign accept_self_id_packets = st_q.link.selfid;

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Ones written to the set address appear in the mask next cycle.
  chk_tx_mask_set:
  assert property ((req.wr && req.addr == `IRF_TX_ENABLE_SET) |=>
    ((st_q.tx_mask & $past(wdata[7:0])) == $past(wdata[7:0])))
  else $error("transmit enable set write lost");

  // Ones written to the clear address leave the mask, zeros change nothing.
  chk_tx_mask_clear:
  assert property ((req.wr && req.addr == `IRF_TX_ENABLE_CLEAR) |=>
    (st_q.tx_mask == ($past(st_q.tx_mask) & ~$past(wdata[7:0]))))
  else $error("transmit enable clear write wrong");

  // Bits 31:8 read zero at every offset but the link words.
  chk_reserved_zero:
  assert property ((req.rd && req.addr != `IRF_LINK_FLAGS_SET &&
    req.addr != `IRF_LINK_FLAGS_CLEAR) |-> (rd_data[31:8] == 24'h00_0000))
  else $error("reserved bits read nonzero");

  // The clear address reads flags combined with the enables.
  chk_rx_clear_read:
  assert property ((req.rd && req.addr == `IRF_RX_FLAGS_CLEAR) |->
    (rd_data == {28'h000_0000, st_q.rx_flags & st_q.rx_mask}))
  else $error("receive clear address read wrong");

  // A rising context line sets its flag one cycle later, even under a clear.
  chk_rx_edge_set:
  assert property ((rx_edge != 4'h0) |=>
    ((st_q.rx_flags & $past(rx_edge)) == $past(rx_edge)))
  else $error("receive completion edge lost");

  // A flag falls only where a clear write carried a one.
  chk_rx_sticky:
  assert property (1'b1 |=>
    ((~st_q.rx_flags & $past(st_q.rx_flags) & ~$past(rx_clr_vec)) == 4'h0))
  else $error("receive flag cleared without a clear write");

  // An enabled completion raises the receive summary next cycle.
  chk_rx_summary:
  assert property (((rx_edge & st_q.rx_mask) != 4'h0) |=> rx_summary_irq)
  else $error("receive summary missed an enabled event");

  // The overlong cycle event drops the master flag.
  chk_master_drop:
  assert property ($rose(overlong_cycle_event) |=> !cycle_start_generator_enable)
  else $error("master flag survived an overlong cycle");

  // While the event stands, the master flag cannot be set again.
  chk_master_refuse:
  assert property ((overlong_cycle_event && !cycle_start_generator_enable) |=>
    !cycle_start_generator_enable)
  else $error("master flag set during an overlong cycle");

  // Writes never reach the fairness field; it follows the arbiter only.
  chk_fair_readonly:
  assert property ((req.wr && req.addr == `IRF_ARB_FAIRNESS) |=>
    (pri_req_limit == $past(fairness_limit)))
  else $error("fairness field changed by a write");

  // The link word read at the clear address shows only implemented positions.
  chk_link_reserved:
  assert property ((req.rd && req.addr == `IRF_LINK_FLAGS_CLEAR) |->
    ((rd_data & ~`IRF_LINK_IMPL_MASK) == 32'h0000_0000))
  else $error("link reserved bit read nonzero");

endmodule : irf_regs

// file: verif/irf_regs_tb.sv
// Purpose: Self-checking bench for irf_regs driven over AHB-Lite.
// Assumes: One wait state per transfer; CYCLE_TICKS cut to 8.
// Notes:   Random data come from an LFSR seeded with 98276.
`timescale 1ns/100ps
module irf_regs_tb;
  import irf_pkg::*;
  // ------------------------------------------------------------
  // Stimulus, model state and outputs.
  // ------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, ovl = 1'b0, hrdy, hresp, txs, rxs, roll;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lk = 32'h0, rd, lf = 32'd98276;
  logic [7:0] tev = 8'h0, fl = 8'h5a, tm = 8'h0, prl;
  logic [3:0] rxi = 4'h0, rf = 4'h0, rm = 4'h0;
  logic [11:0] off;
  logic [4:0] lnk;
  logic cyc = 1'b0; // External cycle pin.
  int err_total = 0, check_count = 0, n;
  // Pairs sit at even and odd index so that index^1 is the twin address.
  logic [7:0] amap [10] = '{8'h98, 8'h9c, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'he0, 8'he4, 8'hdc, 8'hf0};
  irf_regs #(.CYCLE_TICKS(8)) dut (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .tx_event_flags(tev),
    .tx_summary_irq(txs), .rx_ctx_irq(rxi), .rx_summary_irq(rxs),
    .overlong_cycle_event(ovl), .cycle_in(cyc), .cycle_rollover(roll),
    .cycle_offset(off), .fairness_limit(fl), .pri_req_limit(prl),
    .external_cycle_select(lnk[4]), .cycle_start_generator_enable(lnk[3]),
    .cycle_count_enable(lnk[2]), .accept_phy_packets(lnk[1]),
    .accept_self_id_packets(lnk[0]));
  initial forever #5 clk = ~clk;
  // ------------------------------------------------------------
  // Helpers: LFSR, expected reads, model writes, bus, compares.
  // ------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h98, 8'h9c: return {24'h0, tm};
      8'ha0: return {28'h0, rf};
      8'ha4: return {28'h0, rf & rm};
      8'ha8, 8'hac: return {28'h0, rm};
      8'hdc: return {24'h0, fl};
      8'he0, 8'he4: return lk;
      default: return 32'h0;
    endcase
  endfunction : exp_rd
  task automatic upd(input logic [7:0] a, input logic [31:0] d);
    case (a)
      8'h98: tm = tm | d[7:0];
      8'h9c: tm = tm & ~d[7:0];
      8'ha0: rf = rf | d[3:0];
      8'ha4: rf = rf & ~d[3:0];
      8'ha8: rm = rm | d[3:0];
      8'hac: rm = rm & ~d[3:0];
      8'he0: lk = lk | (d & (ovl ? 32'h0050_0600 : 32'h0070_0600));
      8'he4: lk = lk & ~d;
      default: ;
    endcase
  endtask : upd
  task automatic test_done();
    $display("TB: errors %0d of %0d checks", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Bounded wait for an edge at which hready is sampled high.
  task automatic hrdy_wait();
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (hrdy !== 1'b1 && t < 20);
    if (hrdy !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask : hrdy_wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hrdy_wait();
    htrans <= 2'h0;
    hwdata <= d;
    hrdy_wait();
    rd = hrdata;
    if (w)
      upd(a, d);
  endtask : bus
  task automatic chk_pins();
    repeat (2) @(posedge clk);
    cmp({31'h0, txs}, {31'h0, |(tev & tm)});
    cmp({31'h0, rxs}, {31'h0, |(rf & rm)});
    cmp({27'h0, lnk}, {27'h0, lk[22:20], lk[10:9]});
    cmp({31'h0, hresp}, 32'h0);
  endtask : chk_pins
  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cmp({24'h0, prl}, 32'h0);
    @(posedge clk);
    // Reset values of every address, the unmapped one included.
    foreach (amap[i]) begin
      bus(1'b0, amap[i], 32'h0);
      cmp(rd, exp_rd(amap[i]));
    end
    // Random set and clear writes, each read back at both addresses.
    for (int k = 0; k < 60; k++) begin
      lf = nxt(lf);
      tev <= lf[7:0];
      fl <= lf[15:8];
      n = lf[23:16] % 10;
      bus(1'b1, amap[n], nxt(lf));
      bus(1'b0, amap[n], 32'h0);
      cmp(rd, exp_rd(amap[n]));
      bus(1'b0, amap[n ^ 1], 32'h0);
      cmp(rd, exp_rd(amap[n ^ 1]));
      chk_pins();
    end
    // A line held high sets its flag once; a clear then sticks.
    bus(1'b1, 8'ha8, 32'hf);
    rxi <= 4'ha;
    @(posedge clk);
    rf = rf | 4'ha;
    bus(1'b0, 8'ha0, 32'h0);
    cmp(rd, exp_rd(8'ha0));
    bus(1'b1, 8'ha4, 32'hf);
    bus(1'b0, 8'ha4, 32'h0);
    cmp(rd, exp_rd(8'ha4));
    chk_pins();
    // Overlong cycle drops the master flag and blocks setting it.
    bus(1'b1, 8'he0, 32'h0020_0000);
    ovl <= 1'b1;
    lk[21] = 1'b0;
    bus(1'b1, 8'he0, 32'h0020_0000);
    bus(1'b0, 8'he4, 32'h0);
    cmp(rd, exp_rd(8'he4));
    chk_pins();
    ovl <= 1'b0;
    bus(1'b1, 8'he0, 32'h0020_0000);
    chk_pins();
    // Internal rollover every 8 ticks: about 12 rolls in 400 clocks.
    bus(1'b1, 8'he4, 32'hffff_ffff);
    bus(1'b1, 8'he0, 32'h0010_0000);
    // A stale offset from external mode wraps at the first tick.
    repeat (20) @(posedge clk);
    n = 0;
    repeat (400) begin
      @(posedge clk);
      n = n + (roll === 1'b1);
      cmp({31'h0, off < 12'h8}, 32'h1);
    end
    cmp({31'h0, n inside {[11:13]}}, 32'h1);
    // External source: the pin edge rolls over after two sync stages.
    bus(1'b1, 8'he0, 32'h0040_0000);
    cyc <= 1'b1;
    repeat (4) @(posedge clk);
    cmp({31'h0, roll}, 32'h1);
    cmp({20'h0, off}, 32'h0);
    test_done();
  end
endmodule : irf_regs_tb
